// file: design/pam_mask_bank.sv
// Alert mask bank: seven category masks gating status bits onto the alert pin.
// Assumes the transaction engine, status registers and nonvolatile store share clk.

module pam_mask_bank (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic req_valid,
  input wire pam_pkg::pam_req_t req,
  input wire logic [7:0] phase_sel,
  input wire logic nvm_valid,
  input wire pam_pkg::pam_cat_t nvm_image,
  input wire pam_pkg::pam_cat_t status,
  output pam_pkg::pam_rsp_t rsp,
  output pam_pkg::pam_cat_t mask_image,
  output logic loaded,
  output logic alert_out,
  output logic alert_oe_n
);

  //////////////////////////////////////////////////////////////////////////////
  // Request decode

  pam_pkg::pam_state_t state;
  pam_pkg::pam_state_t next_state;
  logic [7:0] sel_off;
  logic [2:0] idx;
  logic sel_hit;
  logic phase_ok;
  logic accept;
  logic wr_take;

  // Selector to category index; out-of-range selectors miss
  assign sel_off = req.sel - pam_pkg::SEL_VOUT;
  assign idx = sel_off[2:0];
  assign sel_hit = (sel_off < 8'(pam_pkg::NCAT));
  // Categories below CAT_OTHER need the all-phases selector
  assign phase_ok = (idx >= pam_pkg::CAT_OTHER) || (phase_sel == pam_pkg::PHASE_ALL);
  assign accept = req_valid && (state == pam_pkg::PAM_RUN) && sel_hit && phase_ok;
  assign wr_take = accept && !req.rd;

  //////////////////////////////////////////////////////////////////////////////
  // Load state: host requests are refused until the first image arrives

  always_comb
  begin
    next_state = state;
    case (state)
      pam_pkg::PAM_WAIT_NVM:
      begin
        if (nvm_valid)
        begin
          next_state = pam_pkg::PAM_RUN;
        end
      end
      pam_pkg::PAM_RUN:
      begin
        next_state = pam_pkg::PAM_RUN;
      end
      default:
      begin
        next_state = pam_pkg::PAM_WAIT_NVM;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= pam_pkg::PAM_WAIT_NVM;
      loaded <= 1'b0;
    end
    else
    begin
      state <= next_state;
      loaded <= (next_state == pam_pkg::PAM_RUN);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Mask storage, one byte per category

  wire [7:0] next_mask [pam_pkg::NCAT];
  wire [pam_pkg::NCAT-1:0] hot;

  genvar g;
  generate
    for (g = 0; g < pam_pkg::NCAT; g++)
    begin : g_cat
      // Nonvolatile image wins over a host write in the same cycle, so a
      // restore is never half overwritten. Read-only bits are forced on the
      // image and write paths, which keeps them fixed whatever the host writes.
      assign next_mask[g] = nvm_valid ?
        ((nvm_image[g] & pam_pkg::WR_BITS[g]) | pam_pkg::FIX_ONES[g]) :
        (wr_take && (idx == 3'(g))) ?
        ((req.data & pam_pkg::WR_BITS[g]) | pam_pkg::FIX_ONES[g]) :
        mask_image[g];
      // Status bits pass untouched; the mask only gates alert drive
      assign hot[g] = |(status[g] & ~mask_image[g]);
    end
  endgenerate

  // Vendor self-check and sync bits are plain writable bits; clearing them
  // can let power-up or stack-enable glitches through
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < pam_pkg::NCAT; i++)
      begin
        mask_image[i] <= (pam_pkg::MASK_PRELOAD & pam_pkg::WR_BITS[i]) | pam_pkg::FIX_ONES[i];
      end
    end
    else
    begin
      for (int i = 0; i < pam_pkg::NCAT; i++)
      begin
        mask_image[i] <= next_mask[i];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Answer: every request gets one answer cycle

  pam_pkg::pam_rsp_t next_rsp;

  always_comb
  begin
    next_rsp.valid = req_valid;
    next_rsp.ok = accept;
    next_rsp.data = 8'h00;
    if (accept && req.rd)
    begin
      next_rsp.data = mask_image[idx];
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rsp <= '0;
    end
    else
    begin
      rsp <= next_rsp;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Alert pin, open drain: level is always low, enable decides

  logic next_alert_on;

  // Registered so the pin never glitches on status decode
  assign next_alert_on = |hot;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      alert_out <= 1'b0;
      alert_oe_n <= 1'b1;
    end
    else
    begin
      alert_out <= 1'b0;
      alert_oe_n <= !next_alert_on;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  logic [2:0] chk_idx;
  logic [7:0] chk_data;

  // Helper: last request index and data, for one-cycle-later checks
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      chk_idx <= 3'h0;
      chk_data <= 8'h00;
    end
    else
    begin
      chk_idx <= idx;
      chk_data <= req.data;
    end
  end

  a_write_lands: assert property (
    @(posedge clk) disable iff (!rst_b)
    (wr_take && !nvm_valid) |=> mask_image[chk_idx] ==
      ((chk_data & pam_pkg::WR_BITS[chk_idx]) | pam_pkg::FIX_ONES[chk_idx]))
    else $error("mask write did not land");

  a_read_returns: assert property (
    @(posedge clk) disable iff (!rst_b)
    (accept && req.rd) |=> (rsp.valid && rsp.ok && rsp.data == $past(mask_image[idx])))
    else $error("mask read returned wrong byte");

  a_vout_low_zero: assert property (
    @(posedge clk) disable iff (!rst_b)
    mask_image[pam_pkg::CAT_VOUT][1:0] == 2'h0)
    else $error("vout mask low bits not zero");

  a_iout_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mask_image[pam_pkg::CAT_IOUT] & 8'h4f) == 8'h00)
    else $error("iout read-only bits not zero");

  a_input_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mask_image[pam_pkg::CAT_INPUT] & 8'hf7) == 8'h00)
    else $error("input read-only bits not zero");

  a_temp_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    mask_image[pam_pkg::CAT_TEMP][5:0] == 6'h00)
    else $error("temperature low bits not zero");

  a_cml_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mask_image[pam_pkg::CAT_CML] & 8'h0d) == 8'h00)
    else $error("comm mask read-only bits not zero");

  a_other_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    mask_image[pam_pkg::CAT_OTHER] == 8'h01)
    else $error("other mask not fixed at one");

  a_mfr_fixed: assert property (
    @(posedge clk) disable iff (!rst_b)
    (mask_image[pam_pkg::CAT_MFR] & 8'h31) == 8'h00)
    else $error("vendor read-only bits not zero");

  a_phase_refuse: assert property (
    @(posedge clk) disable iff (!rst_b)
    (req_valid && sel_hit && idx < pam_pkg::CAT_OTHER && phase_sel != pam_pkg::PHASE_ALL
      && !nvm_valid)
    |=> (rsp.valid && !rsp.ok && $stable(mask_image)))
    else $error("phased access not refused");

  a_nvm_load: assert property (
    @(posedge clk) disable iff (!rst_b)
    nvm_valid |=> mask_image[pam_pkg::CAT_MFR] ==
      ((chk_data & 8'h00) | ($past(nvm_image[pam_pkg::CAT_MFR]) & pam_pkg::WR_BITS[pam_pkg::CAT_MFR])))
    else $error("nonvolatile image not loaded");

  a_alert_follows: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 (alert_oe_n == !$past(|hot)))
    else $error("alert pin does not follow unmasked status");

  a_alert_level: assert property (
    @(posedge clk) disable iff (!rst_b)
    alert_out == 1'b0)
    else $error("alert level not low");

  a_rsp_timing: assert property (
    @(posedge clk) disable iff (!rst_b)
    ##1 (rsp.valid == $past(req_valid)))
    else $error("answer not one cycle after request");

  a_refuse_quiet: assert property (
    @(posedge clk) disable iff (!rst_b)
    (req_valid && !accept && !nvm_valid)
    |=> (!rsp.ok && rsp.data == 8'h00 && $stable(mask_image)))
    else $error("refused request changed state");

  a_nvm_wins: assert property (
    @(posedge clk) disable iff (!rst_b)
    nvm_valid |=> mask_image == (($past(nvm_image) & pam_pkg::WR_BITS) | pam_pkg::FIX_ONES))
    else $error("nonvolatile image did not take every category");

  a_preload_refuse: assert property (
    @(posedge clk) disable iff (!rst_b)
    (req_valid && state == pam_pkg::PAM_WAIT_NVM) |=> (rsp.valid && !rsp.ok))
    else $error("request taken before nonvolatile load");

  c_write: cover property (@(posedge clk) disable iff (!rst_b) wr_take);
  c_read: cover property (@(posedge clk) disable iff (!rst_b) accept && req.rd);
  c_refuse: cover property (@(posedge clk) disable iff (!rst_b) req_valid && !accept);
  c_alert: cover property (@(posedge clk) disable iff (!rst_b) $fell(alert_oe_n));
  c_nvm_write: cover property (@(posedge clk) disable iff (!rst_b) nvm_valid && wr_take);

endmodule

// file: shared/pam_pkg.sv
// Constants and carriers for the alert mask bank.
// Assumes one clock domain shared with the bus transaction engine and status logic.
package pam_pkg;

  // Category count and shared command code
  localparam int NCAT = 7;
  localparam logic [7:0] CMD_ALERT_MASK = 8'h1b;
  localparam logic [7:0] PHASE_ALL = 8'hff;

  // Selectors, one per category, contiguous from vout to vendor
  localparam logic [7:0] SEL_VOUT = 8'h7a;
  localparam logic [7:0] SEL_IOUT = 8'h7b;
  localparam logic [7:0] SEL_INPUT = 8'h7c;
  localparam logic [7:0] SEL_TEMP = 8'h7d;
  localparam logic [7:0] SEL_CML = 8'h7e;
  localparam logic [7:0] SEL_OTHER = 8'h7f;
  localparam logic [7:0] SEL_MFR = 8'h80;

  // Category indices (selector minus SEL_VOUT)
  localparam logic [2:0] CAT_VOUT = 3'h0;
  localparam logic [2:0] CAT_IOUT = 3'h1;
  localparam logic [2:0] CAT_INPUT = 3'h2;
  localparam logic [2:0] CAT_TEMP = 3'h3;
  localparam logic [2:0] CAT_CML = 3'h4;
  localparam logic [2:0] CAT_OTHER = 3'h5;
  localparam logic [2:0] CAT_MFR = 3'h6;

  // Writable bits per category, index 0 at the right
  localparam logic [NCAT-1:0][7:0] WR_BITS = {
    8'hce, // vendor: 7 por, 6 self check, 3 reset pin, 2 back channel, 1 sync
    8'h00, // other: nothing writable
    8'hf2, // comm/logic: 7,6,5,4,1
    8'hc0, // temperature: 7,6
    8'h08, // input: 3
    8'hb0, // output current: 7,5,4
    8'hfc  // output voltage: 7..2
  };

  // Read-only bits that are fixed at one
  localparam logic [NCAT-1:0][7:0] FIX_ONES = {
    8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00
  };

  // Value held before nonvolatile load: every writable bit masked
  localparam logic [7:0] MASK_PRELOAD = 8'hff;

  typedef logic [NCAT-1:0][7:0] pam_cat_t;

  typedef struct packed {
    logic rd; // 1: block process call read, 0: word write
    logic [7:0] sel;
    logic [7:0] data;
  } pam_req_t;

  typedef struct packed {
    logic valid;
    logic ok;
    logic [7:0] data;
  } pam_rsp_t;

  typedef enum logic {PAM_WAIT_NVM, PAM_RUN} pam_state_t;

endpackage

// file: test/pam_host_model.sv
// Host-side model of the transaction engine: one mask request per call.
// Assumes a free-running clk and a bench that waits for reset release first.
module pam_host_model (
  input wire logic clk,
  input wire pam_pkg::pam_rsp_t rsp,
  output logic req_valid,
  output pam_pkg::pam_req_t req
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end
  // Word write or process call on the one shared command code
  task automatic xfer(input logic rd, input logic [7:0] sel, input logic [7:0] data,
                      output pam_pkg::pam_rsp_t r);
    @(negedge clk);
    req_valid = 1'b1;
    req = '{rd: rd, sel: sel, data: rd ? 8'h00 : data};
    @(negedge clk);
    r = rsp;
    req_valid = 1'b0;
    // Released lines flip so a stale value is never read as fresh
    req = ~req;
  endtask
endmodule

// file: test/pam_mask_bank_test.sv
// Self-checking bench for the alert mask bank.
// Assumes the host model issues requests; the bench drives nvm, status and phase.
module pam_mask_bank_test;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic rd;
    logic [7:0] sel;
    logic [7:0] data;
    logic [7:0] ph;
    logic [9:0] exp;
  } pam_row_t;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic req_valid;
  pam_pkg::pam_req_t req;
  logic [7:0] phase_sel = 8'hff;
  logic nvm_valid = 1'b0;
  pam_pkg::pam_cat_t nvm_image = '1;
  pam_pkg::pam_cat_t status = '0;
  pam_pkg::pam_rsp_t rsp;
  pam_pkg::pam_cat_t mask_image;
  logic loaded;
  logic alert_out;
  logic alert_oe_n;
  pam_pkg::pam_rsp_t r;
  pam_row_t rows[$];
  logic [7:0] d;
  int errors = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  pam_mask_bank DUT (.clk(clk), .rst_b(rst_b), .req_valid(req_valid), .req(req),
    .phase_sel(phase_sel), .nvm_valid(nvm_valid), .nvm_image(nvm_image),
    .status(status), .rsp(rsp), .mask_image(mask_image), .loaded(loaded),
    .alert_out(alert_out), .alert_oe_n(alert_oe_n));
  pam_host_model host (.clk(clk), .rsp(rsp), .req_valid(req_valid), .req(req));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One status bit alone; pin follows after one register stage
  task automatic alert_case(input int cat, input int b, input logic exp);
    @(negedge clk);
    status = '0;
    status[cat][b] = 1'b1;
    repeat (2) @(negedge clk);
    check(alert_oe_n, exp);
    check(alert_out, 1'b0);
  endtask
  // Hang guard, far above the hundred or so cycles the run needs
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      errors = errors + 1;
      print_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    // Each category: two opposite patterns, read back, then off all-phases
    for (int i = 0; i < 7; i++)
    begin
      for (int k = 0; k < 2; k++)
      begin
        d = k ? 8'ha5 : 8'h5a;
        rows.push_back('{1'b0, pam_pkg::SEL_VOUT + 8'(i), d, 8'hff, 10'h300});
        rows.push_back('{1'b1, pam_pkg::SEL_VOUT + 8'(i), 8'h00, 8'hff,
          {2'b11, d & pam_pkg::WR_BITS[i] | pam_pkg::FIX_ONES[i]}});
      end
      rows.push_back('{1'b1, pam_pkg::SEL_VOUT + 8'(i), 8'h00, 8'h00,
        i > 4 ? {2'b11, d & pam_pkg::WR_BITS[i] | pam_pkg::FIX_ONES[i]} : 10'h200});
    end
    rows.push_back('{1'b0, 8'h79, 8'h00, 8'hff, 10'h200});
    rows.push_back('{1'b0, 8'h81, 8'h00, 8'hff, 10'h200});
    rows.push_back('{1'b0, pam_pkg::SEL_VOUT, 8'h00, 8'h00, 10'h200});
    rows.push_back('{1'b1, pam_pkg::SEL_VOUT, 8'h00, 8'hff, 10'h3a4});
    // In reset every writable bit masked, pin released
    repeat (12) @(negedge clk);
    check(mask_image, pam_pkg::WR_BITS | pam_pkg::FIX_ONES);
    check({loaded, alert_oe_n}, 2'b01);
    rst_b = 1'b1;
    host.xfer(1'b1, pam_pkg::SEL_VOUT, 8'h00, r);
    check(r, 10'h200);
    // Image with read-only bits set; they must be forced back
    @(negedge clk);
    nvm_image = ~pam_pkg::WR_BITS;
    nvm_valid = 1'b1;
    @(negedge clk);
    nvm_valid = 1'b0;
    check(mask_image, pam_pkg::FIX_ONES);
    check(loaded, 1'b1);
    alert_case(pam_pkg::CAT_MFR, 6, 1'b0);
    alert_case(pam_pkg::CAT_MFR, 1, 1'b0);
    alert_case(pam_pkg::CAT_OTHER, 0, 1'b1);
    alert_case(pam_pkg::CAT_VOUT, 7, 1'b0);
    status = '0;
    repeat (2) @(negedge clk);
    check(alert_oe_n, 1'b1);
    foreach (rows[i])
    begin
      phase_sel = rows[i].ph;
      host.xfer(rows[i].rd, rows[i].sel, rows[i].data, r);
      check(r, rows[i].exp);
    end
    // Temperature mask now 80: bit 7 blocked, bit 6 passes
    alert_case(pam_pkg::CAT_TEMP, 7, 1'b1);
    alert_case(pam_pkg::CAT_TEMP, 6, 1'b0);
    // Image and host write in one cycle: image wins, write still answered
    fork
      host.xfer(1'b0, pam_pkg::SEL_VOUT, 8'hff, r);
      #10 nvm_valid = 1'b1;
      #20 nvm_valid = 1'b0;
    join
    check(r, 10'h300);
    check(mask_image, pam_pkg::FIX_ONES);
    // Second reset in mid-run, status still active; refused until reloaded
    rst_b = 1'b0;
    @(negedge clk);
    check(mask_image, pam_pkg::WR_BITS | pam_pkg::FIX_ONES);
    check({loaded, alert_oe_n, rsp.valid}, 3'b010);
    rst_b = 1'b1;
    host.xfer(1'b1, pam_pkg::SEL_TEMP, 8'h00, r);
    check({r, alert_oe_n}, 11'h401);
    print_verdict();
  end
endmodule
